// ### src/wssd_top.sv
// Steering, auto-shutdown and dead-band stage of the complementary waveform unit.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.

module wssd_top #(
	parameter int DIN_N = wssd_pkg::DATA_SRC_N
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Avalon-MM slave
	input wire logic [wssd_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Generator clock enable when the internal oscillator is chosen
	input wire logic hfosc_tick,
	// Data waveform candidates
	input wire logic [DIN_N-1:0] data_sources,
	// Auto-shutdown sources
	input wire wssd_pkg::wssd_shut_s shut_sources,
	// Bridge driver pins
	output wssd_pkg::wssd_pins_s bridge,
	// Interrupt
	output logic irq
);

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic ack_q;
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic wr_go;
	logic [7:0] wd;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata = rd_q;
	assign wr_go = avs_write & ack_q & avs_byteenable[0];
	assign wd = avs_writedata[7:0];

	function automatic logic wr_hit(input logic go, input logic [wssd_pkg::AW-1:0] adr,
		input logic [wssd_pkg::AW-1:0] off);
		return go && (adr == off);
	endfunction

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			rd_q <= rd_d;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic en_q;
	logic ld_q;
	logic [2:0] mode_q;
	logic [3:0] pol_q;
	logic cs_q;
	logic [4:0] is_q;
	logic [7:0] str_q;
	logic [3:0] str_act_q;
	logic ren_q;
	logic [1:0] shutdown_state_bd_q;
	logic [1:0] shutdown_state_ac_q;
	logic [6:0] ase_q;
	logic [5:0] dbr_q;
	logic [5:0] dbf_q;
	logic [5:0] dbr_act_q;
	logic [5:0] dbf_act_q;
	logic [1:0] imask_q;
	logic sd_q;
	logic [1:0] ist_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0;
			mode_q <= wssd_pkg::MODE_ASYNC_STEER;
			pol_q <= 4'h0;
			cs_q <= 1'b0;
			is_q <= 5'h00;
			str_q <= 8'h00;
			ren_q <= wssd_pkg::RST_SHUT_CTRL0[wssd_pkg::SC0_REN];
			shutdown_state_bd_q <= wssd_pkg::RST_SHUT_CTRL0[wssd_pkg::SC0_SHUTDOWN_STATE_BD +: 2];
			shutdown_state_ac_q <= wssd_pkg::RST_SHUT_CTRL0[wssd_pkg::SC0_SHUTDOWN_STATE_AC +: 2];
			ase_q <= 7'h00;
			dbr_q <= wssd_pkg::RST_DB_COUNT;
			dbf_q <= wssd_pkg::RST_DB_COUNT;
			imask_q <= 2'h0;
		end else begin
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_GEN_CTRL0)) begin
				en_q <= wd[wssd_pkg::GC0_EN];
				mode_q <= wd[2:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_GEN_CTRL1)) begin
				pol_q <= wd[3:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_CLK_SEL)) begin
				cs_q <= wd[0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_DIN_SEL)) begin
				is_q <= wd[4:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_STEER)) begin
				str_q <= wd;
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_SHUT_CTRL0)) begin
				ren_q <= wd[wssd_pkg::SC0_REN];
				shutdown_state_bd_q <= wd[wssd_pkg::SC0_SHUTDOWN_STATE_BD +: 2];
				shutdown_state_ac_q <= wd[wssd_pkg::SC0_SHUTDOWN_STATE_AC +: 2];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_SHUT_SRC_EN)) begin
				ase_q <= wd[6:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_RISE_DB)) begin
				dbr_q <= wd[5:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_FALL_DB)) begin
				dbf_q <= wd[5:0];
			end
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_IRQ_MASK)) begin
				imask_q <= wd[1:0];
			end
		end
	end

	// ************************************************************
	// Data input selection
	// ************************************************************
	logic din_q;
	logic din_p_q;
	logic din_rise;
	logic din_fall;
	logic gen_tick;
	logic steer_mode;

	assign din_rise = din_q & ~din_p_q;
	assign din_fall = ~din_q & din_p_q;
	assign gen_tick = cs_q ? hfosc_tick : 1'b1;
	assign steer_mode = (mode_q[2:1] == 2'h0);

	// Reserved selections read as a constant low so no stray edge reaches the outputs.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			din_q <= 1'b0;
			din_p_q <= 1'b0;
		end else begin
			din_q <= (int'(is_q) < DIN_N) ? data_sources[is_q] : 1'b0;
			din_p_q <= din_q;
		end
	end

	// ************************************************************
	// Steering buffer
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			str_act_q <= 4'h0;
		end else if (mode_q == wssd_pkg::MODE_SYNC_STEER) begin
			if (din_rise) begin
				str_act_q <= str_q[3:0];
			end
		end else begin
			str_act_q <= str_q[3:0];
		end
	end

	// ************************************************************
	// Dead-band count buffers
	// ************************************************************
	logic ld_arm_q;

	// Counts load freely while disabled; once running only the load request updates them.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ld_q <= 1'b0;
			ld_arm_q <= 1'b0;
			dbr_act_q <= wssd_pkg::RST_DB_COUNT;
			dbf_act_q <= wssd_pkg::RST_DB_COUNT;
		end else if (!en_q) begin
			ld_q <= 1'b0;
			ld_arm_q <= 1'b0;
			dbr_act_q <= dbr_q;
			dbf_act_q <= dbf_q;
		end else begin
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_GEN_CTRL0) && wd[wssd_pkg::GC0_LD]) begin
				ld_q <= 1'b1;
			end else if (ld_arm_q && din_rise) begin
				ld_q <= 1'b0;
			end
			if (ld_arm_q && din_rise) begin
				ld_arm_q <= 1'b0;
				dbr_act_q <= dbr_q;
				dbf_act_q <= dbf_q;
			end else if (ld_q && din_fall) begin
				ld_arm_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Dead-band delay
	// ************************************************************
	logic dly_q;
	logic [5:0] db_cnt_q;
	logic [5:0] db_n;

	assign db_n = din_q ? dbr_act_q : dbf_act_q;

	// The first generator tick may come at any phase, hence the N to N+1 spread.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dly_q <= 1'b0;
			db_cnt_q <= 6'h00;
		end else if (!en_q || din_q == dly_q) begin
			dly_q <= din_q;
			db_cnt_q <= 6'h00;
		end else if (db_n == 6'h00) begin
			dly_q <= din_q;
			db_cnt_q <= 6'h00;
		end else if (gen_tick) begin
			if (db_cnt_q == db_n) begin
				dly_q <= din_q;
				db_cnt_q <= 6'h00;
			end else begin
				db_cnt_q <= db_cnt_q + 6'h01;
			end
		end
	end

	// ************************************************************
	// Auto-shutdown
	// ************************************************************
	logic sd_src;
	logic sd_set;
	logic sd_clr;
	logic sd_wr;
	logic hold_q;
	logic held;

	assign sd_src = |(ase_q & shut_sources);
	assign sd_wr = wr_hit(wr_go, avs_address, wssd_pkg::OFF_SHUT_CTRL0);
	assign sd_set = (en_q & sd_src) | (sd_wr & wd[wssd_pkg::SC0_SHUTDOWN]);
	assign sd_clr = (en_q & ren_q & ~sd_src) | (sd_wr & ~wd[wssd_pkg::SC0_SHUTDOWN]);
	assign held = sd_q | hold_q;

	// A set in the same cycle as a clear wins, so a live source is never dropped.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sd_q <= 1'b0;
		end else if (sd_set) begin
			sd_q <= 1'b1;
		end else if (sd_clr) begin
			sd_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_q <= 1'b0;
		end else if (sd_q) begin
			hold_q <= 1'b1;
		end else if (din_rise) begin
			hold_q <= 1'b0;
		end
	end

	// ************************************************************
	// Output stage
	// ************************************************************
	logic [3:0] lvl_d;
	logic [3:0] oe_d;

	function automatic logic [1:0] shut_pin(input logic [1:0] ls, input logic pol, input logic cur,
		input logic dly);
		case (ls)
			wssd_pkg::LS_DRIVE_HIGH: shut_pin = 2'h3;
			wssd_pkg::LS_DRIVE_LOW: shut_pin = 2'h2;
			wssd_pkg::LS_TRISTATE: shut_pin = 2'h0;
			default: shut_pin = {1'b1, dly ? cur : pol};
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_out
			logic [1:0] ls;
			logic [1:0] sp;
			logic norm;
			assign ls = (gi % 2 == 0) ? shutdown_state_ac_q : shutdown_state_bd_q;
			assign sp = shut_pin(ls, pol_q[gi], bridge.level[gi], dly_q);
			assign norm = (!en_q || !steer_mode) ? pol_q[gi] :
				(str_act_q[gi] ? (dly_q ^ pol_q[gi]) : str_q[wssd_pkg::STR_OVR + gi]);
			assign lvl_d[gi] = held ? sp[0] : norm;
			assign oe_d[gi] = held ? sp[1] : 1'b1;
		end
	endgenerate

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bridge <= '{oe: 4'hF, level: 4'h0};
		end else begin
			bridge <= '{oe: oe_d, level: lvl_d};
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	logic sd_p_q;
	logic [1:0] iev;

	assign iev = {~sd_q & sd_p_q, sd_q & ~sd_p_q};
	assign irq = |(ist_q & imask_q);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sd_p_q <= 1'b0;
			ist_q <= 2'h0;
		end else begin
			sd_p_q <= sd_q;
			if (wr_hit(wr_go, avs_address, wssd_pkg::OFF_IRQ_STATUS)) begin
				ist_q <= iev | (ist_q & ~wd[1:0]);
			end else begin
				ist_q <= iev | ist_q;
			end
		end
	end

	// ************************************************************
	// Read mux
	// ************************************************************
	always_comb begin
		rd_d = 32'h0000_0000;
		case (avs_address)
			wssd_pkg::OFF_GEN_CTRL0: rd_d[7:0] = {en_q, ld_q, 3'h0, mode_q};
			wssd_pkg::OFF_GEN_CTRL1: rd_d[7:0] = {2'h0, din_q, 1'b0, pol_q};
			wssd_pkg::OFF_CLK_SEL: rd_d[7:0] = {7'h00, cs_q};
			wssd_pkg::OFF_DIN_SEL: rd_d[7:0] = {3'h0, is_q};
			wssd_pkg::OFF_STEER: rd_d[7:0] = str_q;
			wssd_pkg::OFF_SHUT_CTRL0: rd_d[7:0] = {sd_q, ren_q, shutdown_state_bd_q, shutdown_state_ac_q, 2'h0};
			wssd_pkg::OFF_SHUT_SRC_EN: rd_d[7:0] = {1'b0, ase_q};
			wssd_pkg::OFF_RISE_DB: rd_d[7:0] = {2'h0, dbr_q};
			wssd_pkg::OFF_FALL_DB: rd_d[7:0] = {2'h0, dbf_q};
			wssd_pkg::OFF_IRQ_STATUS: rd_d[7:0] = {6'h00, ist_q};
			wssd_pkg::OFF_IRQ_MASK: rd_d[7:0] = {6'h00, imask_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_steer_follow;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && steer_mode && !held && str_act_q[0]) |=> (bridge.level[0] == $past(dly_q ^ pol_q[0]));
	endproperty
	a_steer_follow: assert property (p_steer_follow) else $error("Steered output A does not follow data.");

	property p_override;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && steer_mode && !held && !str_act_q[3]) |=> (bridge.level[3] == $past(str_q[7]));
	endproperty
	a_override: assert property (p_override) else $error("Unsteered output D does not show override.");

	property p_nonsteer;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && !steer_mode && !held) |=> (bridge.level == $past(pol_q) && bridge.oe == 4'hF);
	endproperty
	a_nonsteer: assert property (p_nonsteer) else $error("Steering bits acted outside steering modes.");

	property p_sync_buffer;
		@(posedge core_clk) disable iff (!arst_n)
		(mode_q == wssd_pkg::MODE_SYNC_STEER && !din_rise) |=> $stable(str_act_q);
	endproperty
	a_sync_buffer: assert property (p_sync_buffer) else $error("Synchronous steering took effect early.");

	property p_shut_enter;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && sd_src) |=> sd_q ##1 (held && bridge.oe == $past(oe_d));
	endproperty
	a_shut_enter: assert property (p_shut_enter) else $error("Active source did not shut down.");

	property p_hold_until_rise;
		@(posedge core_clk) disable iff (!arst_n)
		(hold_q && !sd_q && !din_rise) |=> hold_q;
	endproperty
	a_hold_until_rise: assert property (p_hold_until_rise) else $error("Shutdown released before rise.");

	property p_auto_restart;
		@(posedge core_clk) disable iff (!arst_n)
		(sd_q && en_q && ren_q && !sd_src && !sd_wr) |=> !sd_q;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("Auto-restart did not clear shutdown.");

	property p_tristate_bd;
		@(posedge core_clk) disable iff (!arst_n)
		(held && shutdown_state_bd_q == wssd_pkg::LS_TRISTATE) |=> (bridge.oe[1] == 1'b0 && bridge.oe[3] == 1'b0);
	endproperty
	a_tristate_bd: assert property (p_tristate_bd) else $error("Outputs B and D not released.");

	property p_high_ac;
		@(posedge core_clk) disable iff (!arst_n)
		(held && shutdown_state_ac_q == wssd_pkg::LS_DRIVE_HIGH) |=> (bridge.level[0] && bridge.level[2] && bridge.oe[0]);
	endproperty
	a_high_ac: assert property (p_high_ac) else $error("Outputs A and C not driven high.");

	property p_rise_delay;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && din_rise && !dly_q && dbr_act_q > 6'h01) |=> !dly_q [*2];
	endproperty
	a_rise_delay: assert property (p_rise_delay) else $error("Rising edge passed without dead band.");

	property p_fall_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		(en_q && !din_q && dly_q && dbf_act_q == 6'h00) |=> !dly_q;
	endproperty
	a_fall_bypass: assert property (p_fall_bypass) else $error("Zero falling count did not bypass.");

	c_shut_enter: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(sd_q));
	c_auto_restart: cover property (@(posedge core_clk) disable iff (!arst_n) ren_q && $fell(sd_q));
	c_hold_release: cover property (@(posedge core_clk) disable iff (!arst_n) $fell(hold_q));
	c_rise_delay: cover property (@(posedge core_clk) disable iff (!arst_n) dbr_act_q > 6'h02 && $rose(dly_q));

endmodule

// ### src/wssd_pkg.sv
// Package with register map, field positions, reset values and carrier types of the waveform steering block.
package wssd_pkg;

	// ************************************************************
	// Register offsets (byte addresses on the Avalon-MM slave)
	// ************************************************************
	localparam int AW = 6;
	localparam logic [AW-1:0] OFF_GEN_CTRL0 = 6'h00;
	localparam logic [AW-1:0] OFF_GEN_CTRL1 = 6'h04;
	localparam logic [AW-1:0] OFF_CLK_SEL = 6'h08;
	localparam logic [AW-1:0] OFF_DIN_SEL = 6'h0C;
	localparam logic [AW-1:0] OFF_STEER = 6'h10;
	localparam logic [AW-1:0] OFF_SHUT_CTRL0 = 6'h14;
	localparam logic [AW-1:0] OFF_SHUT_SRC_EN = 6'h18;
	localparam logic [AW-1:0] OFF_RISE_DB = 6'h1C;
	localparam logic [AW-1:0] OFF_FALL_DB = 6'h20;
	localparam logic [AW-1:0] OFF_IRQ_STATUS = 6'h24;
	localparam logic [AW-1:0] OFF_IRQ_MASK = 6'h28;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int GC0_EN = 7;
	localparam int GC0_LD = 6;
	localparam int GC1_IN = 5;
	localparam int SC0_SHUTDOWN = 7;
	localparam int SC0_REN = 6;
	localparam int SC0_SHUTDOWN_STATE_BD = 4;
	localparam int SC0_SHUTDOWN_STATE_AC = 2;
	localparam int STR_OVR = 4;
	localparam int IRQ_SHUT_ENTER = 0;
	localparam int IRQ_SHUT_LEAVE = 1;

	// ************************************************************
	// Reset values and encodings
	// ************************************************************
	localparam logic [7:0] RST_SHUT_CTRL0 = 8'h14;
	localparam logic [5:0] RST_DB_COUNT = 6'h00;
	localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
	localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
	localparam logic [1:0] LS_INACTIVE = 2'h0;
	localparam logic [1:0] LS_TRISTATE = 2'h1;
	localparam logic [1:0] LS_DRIVE_LOW = 2'h2;
	localparam logic [1:0] LS_DRIVE_HIGH = 2'h3;
	localparam int DATA_SRC_N = 19;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic clc;
		logic cmp2;
		logic cmp1;
		logic tmr6;
		logic tmr4;
		logic tmr2;
		logic pin;
	} wssd_shut_s;

	typedef struct packed {
		logic [3:0] oe;
		logic [3:0] level;
	} wssd_pins_s;

endpackage

// ### tb/wssd_bridge_model.sv
// Behavioural model of the bridge driver inputs fed by the four output pins.
module wssd_bridge_model #(
	parameter logic [3:0] PULL = 4'h0
) (
	// Pins from the waveform stage
	input wire wssd_pkg::wssd_pins_s bridge,
	// Levels the power switch drivers see
	output logic [3:0] seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released pin sits on its resistor, never on the last driven value.
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			seen[k] = bridge.oe[k] ? bridge.level[k] : PULL[k];
		end
	end
endmodule

// ### tb/testbench.sv
// Self-checking testbench of the waveform steering, shutdown and dead-band stage.
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
	$display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [wssd_pkg::AW-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hfosc_tick = 1'b0;
	logic [wssd_pkg::DATA_SRC_N-1:0] data_sources = '0;
	wssd_pkg::wssd_shut_s shut_sources = '0;
	wssd_pkg::wssd_pins_s bridge;
	logic irq;
	logic [3:0] seen;
	logic [7:0] rdata;
	int fail_count = 0;
	int checks_done = 0;
	int d0r;
	int d0f;
	int dr;
	int df;

	always #50 core_clk = ~core_clk;

	// Internal oscillator stand-in: a tick on every other clock, so the divided rate is exercised.
	always @(posedge core_clk) hfosc_tick <= ~hfosc_tick;

	wssd_top wssd_top_inst (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .hfosc_tick(hfosc_tick), .data_sources(data_sources),
		.shut_sources(shut_sources), .bridge(bridge), .irq(irq));

	wssd_bridge_model #(.PULL(4'hA)) wssd_bridge_model_inst (.bridge(bridge), .seen(seen));

	// ************************************************************
	// Bus and stimulus tasks
	// ************************************************************
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata[7:0];
		avs_read <= 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Six cycles cover the three-register data path with the dead band bypassed.
	task automatic din(input logic v);
		@(posedge core_clk);
		data_sources[1] <= v;
		cyc(6);
	endtask

	task automatic meas(input logic v, output int n);
		@(posedge core_clk);
		data_sources[1] <= v;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (bridge.level[0] !== v && n < 200);
	endtask

	task automatic finish_test;
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Watchdog
	// ************************************************************
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		finish_test();
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(wssd_pkg::OFF_SHUT_CTRL0);
		`CHECK_EQ(rdata, wssd_pkg::RST_SHUT_CTRL0)
		rd(wssd_pkg::OFF_STEER);
		`CHECK_EQ(rdata, 8'h00)
		rd(6'h3C);
		`CHECK_EQ(rdata, 8'h00)
		`CHECK_EQ(irq, 1'b0)
		avs_byteenable <= 4'hE;
		wr(wssd_pkg::OFF_STEER, 8'h55);
		avs_byteenable <= 4'hF;
		rd(wssd_pkg::OFF_STEER);
		`CHECK_EQ(rdata, 8'h00)
		// Asynchronous steering and override.
		wr(wssd_pkg::OFF_DIN_SEL, 8'h01);
		wr(wssd_pkg::OFF_STEER, 8'hA3);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h80);
		din(1'b1);
		`CHECK_EQ(bridge, 8'hFB)
		din(1'b0);
		`CHECK_EQ(bridge, 8'hF8)
		wr(wssd_pkg::OFF_GEN_CTRL1, 8'h05);
		cyc(4);
		`CHECK_EQ(bridge.level, 4'b1001)
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h82);
		cyc(4);
		`CHECK_EQ(bridge.level, 4'b0101)
		// Synchronous steering holds new enables until a data rise.
		wr(wssd_pkg::OFF_GEN_CTRL1, 8'h0F);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h81);
		din(1'b1);
		din(1'b0);
		`CHECK_EQ(bridge.level, 4'b1011)
		wr(wssd_pkg::OFF_STEER, 8'h0F);
		cyc(4);
		`CHECK_EQ(bridge.level, 4'b0011)
		din(1'b1);
		`CHECK_EQ(bridge.level, 4'b0000)
		din(1'b0);
		`CHECK_EQ(bridge.level, 4'b1111)
		// Each shutdown source, gated by its own enable, with auto-restart.
		wr(wssd_pkg::OFF_GEN_CTRL1, 8'h00);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h80);
		wr(wssd_pkg::OFF_SHUT_CTRL0, 8'h78);
		for (int i = 0; i < 7; i++) begin
			wr(wssd_pkg::OFF_IRQ_MASK, 8'h00);
			wr(wssd_pkg::OFF_SHUT_SRC_EN, 8'h7F & ~(8'h01 << i));
			shut_sources <= wssd_pkg::wssd_shut_s'(7'(1 << i));
			cyc(4);
			`CHECK_EQ(bridge.level, 4'b0000)
			wr(wssd_pkg::OFF_SHUT_SRC_EN, 8'h01 << i);
			cyc(4);
			rd(wssd_pkg::OFF_SHUT_CTRL0);
			`CHECK_EQ(rdata[wssd_pkg::SC0_SHUTDOWN], 1'b1)
			`CHECK_EQ(bridge, 8'hFA)
			`CHECK_EQ(irq, 1'b0)
			wr(wssd_pkg::OFF_IRQ_MASK, 8'h01);
			cyc(1);
			`CHECK_EQ(irq, 1'b1)
			shut_sources <= '0;
			cyc(4);
			rd(wssd_pkg::OFF_SHUT_CTRL0);
			`CHECK_EQ(rdata[wssd_pkg::SC0_SHUTDOWN], 1'b0)
			`CHECK_EQ(bridge, 8'hFA)
			din(1'b1);
			`CHECK_EQ(bridge, 8'hFF)
			din(1'b0);
			wr(wssd_pkg::OFF_IRQ_STATUS, 8'h03);
			cyc(1);
			`CHECK_EQ(irq, 1'b0)
		end
		// Inactive state on B and D, drive high on A and C.
		wr(wssd_pkg::OFF_SHUT_CTRL0, 8'h4C);
		shut_sources <= wssd_pkg::wssd_shut_s'(7'h40);
		cyc(4);
		`CHECK_EQ(bridge, 8'hF5)
		shut_sources <= '0;
		cyc(4);
		din(1'b1);
		`CHECK_EQ(bridge, 8'hFF)
		din(1'b0);
		// Software shutdown while disabled, tri-state, manual restart.
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h00);
		wr(wssd_pkg::OFF_SHUT_CTRL0, 8'h94);
		cyc(4);
		`CHECK_EQ(bridge.oe, 4'h0)
		`CHECK_EQ(seen, 4'hA)
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h80);
		cyc(4);
		rd(wssd_pkg::OFF_SHUT_CTRL0);
		`CHECK_EQ(rdata, 8'h94)
		wr(wssd_pkg::OFF_SHUT_CTRL0, 8'h14);
		cyc(4);
		`CHECK_EQ(bridge.oe, 4'h0)
		din(1'b1);
		`CHECK_EQ(bridge, 8'hFF)
		din(1'b0);
		// Dead band: extra delay of N to N+1 over the bypassed path.
		meas(1'b1, d0r);
		meas(1'b0, d0f);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h00);
		wr(wssd_pkg::OFF_RISE_DB, 8'h03);
		wr(wssd_pkg::OFF_FALL_DB, 8'h05);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h80);
		cyc(4);
		meas(1'b1, dr);
		meas(1'b0, df);
		`CHECK_EQ(d0r == 4 && d0f == 4, 1'b1)
		`CHECK_EQ(dr - d0r inside {3, 4}, 1'b1)
		`CHECK_EQ(df - d0f inside {5, 6}, 1'b1)
		// Generator clock from the oscillator tick, one period being two clocks.
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h00);
		wr(wssd_pkg::OFF_CLK_SEL, 8'h01);
		wr(wssd_pkg::OFF_GEN_CTRL0, 8'h80);
		cyc(4);
		meas(1'b1, dr);
		`CHECK_EQ(dr - d0r inside {[6:8]}, 1'b1)
		finish_test();
	end
endmodule
